// ### design/nor_host.sv
// Host-side sequencer driving an 8-bit asynchronous NAND flash over its pins.
// Assumes one device, ready/busy pulled up outside, and a user that scans the table first.
module nor_host #(
	parameter logic [7:0] CMD_PROG_SETUP = 8'h80,
	parameter logic [7:0] CMD_PROG_CONFIRM = 8'h10,
	parameter logic [7:0] CMD_ERASE_SETUP = 8'h60,
	parameter logic [7:0] CMD_ERASE_CONFIRM = 8'hD0,
	parameter logic [7:0] CMD_STATUS = 8'h70,
	parameter int STAT_FAIL_BIT = 0
) (
	// clock and reset
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	// command
	input wire logic CMD_VALID_I,
	input wire logic [2:0] CMD_OP_I,
	input wire logic [nor_pkg::BLK_W-1:0] CMD_BLOCK_I,
	input wire logic [nor_pkg::PAGE_W-1:0] CMD_PAGE_I,
	input wire logic [nor_pkg::COL_W-1:0] CMD_COL_I,
	input wire logic [nor_pkg::LEN_W-1:0] CMD_LEN_I,
	output logic CMD_READY_O,
	// write data
	input wire logic [7:0] WR_DATA_I,
	input wire logic WR_VALID_I,
	output logic WR_READY_O,
	// read data
	output logic [7:0] RD_DATA_O,
	output logic RD_VALID_O,
	output logic [19:0] ECC_SYND_O,
	// completion
	output logic DONE_O,
	output logic REFUSED_O,
	output logic FAIL_O,
	output logic [7:0] STATUS_O,
	output logic TABLE_READY_O,
	// flash pins
	output logic NAND_CE_N_O,
	output logic NAND_CLE_O,
	output logic NAND_ALE_O,
	output logic NAND_WE_N_O,
	output logic NAND_RE_N_O,
	input wire logic [7:0] NAND_DQ_I,
	output logic [7:0] NAND_DQ_O,
	output logic NAND_DQ_OE_O,
	input wire logic NAND_RB_N_I
);
	// --------------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------------
	nor_pkg::nor_state_t st_q, nxt_q;
	nor_pkg::nor_phase_t ph_q;
	nor_pkg::nor_op_t op_q;
	logic [nor_pkg::CNT_W-1:0] cnt_q;
	logic [7:0] dout_q, din_q, status_q;
	logic [2:0] addr_idx_q;
	logic [nor_pkg::LEN_W-1:0] remain_q;
	logic [nor_pkg::BLK_W-1:0] blk_q, prog_blk_q;
	logic [nor_pkg::PAGE_W-1:0] pg_q, prog_pg_q;
	logic [nor_pkg::COL_W-1:0] col_q, col_ptr_q, syn_idx_q;
	logic [7:0] syn_par_q;
	logic prog_any_q, table_ready_q, refused_q, fail_q, done_q;
	logic scan_pg_q, smp_q, rd_valid_q;
	logic rb_s1_q, rb_s2_q, rb_s3_q, rb_rdy_q;
	logic bbt_wr_q, bbt_wd_q;
	logic wr_st, rd_st, lo_end, hi_end, cnt_end, accept, order_bad, refuse;
	nor_bbt_if bbt ();

	nor_bbt_mem u_bbt (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.port(bbt.mem)
	);

	// --------------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------------
	function automatic logic [7:0] first_cmd(input nor_pkg::nor_op_t op);
		unique case (op)
			nor_pkg::OP_PROG: return CMD_PROG_SETUP;
			nor_pkg::OP_ERASE: return CMD_ERASE_SETUP;
			nor_pkg::OP_RESET: return nor_pkg::CMD_RESET;
			default: return nor_pkg::CMD_READ_SETUP;
		endcase
	endfunction

	function automatic logic [7:0] addr_byte(input logic [2:0] idx,
		input logic [nor_pkg::COL_W-1:0] col, input logic [nor_pkg::ROW_W-1:0] row);
		unique case (idx)
			3'h0: return col[7:0];
			3'h1: return {4'h0, col[11:8]};
			3'h2: return row[7:0];
			3'h3: return row[15:8];
			default: return {7'h00, row[16]};
		endcase
	endfunction // [R13]

	assign wr_st = st_q inside {nor_pkg::ST_CMD_A, nor_pkg::ST_ADDR, nor_pkg::ST_LOAD,
		nor_pkg::ST_CMD_B, nor_pkg::ST_STAT_CMD};
	assign rd_st = st_q inside {nor_pkg::ST_READ, nor_pkg::ST_STAT_RD};
	assign cnt_end = cnt_q == nor_pkg::CNT_ONE;
	assign lo_end = ph_q == nor_pkg::PH_LO && cnt_end;
	assign hi_end = ph_q == nor_pkg::PH_HI && cnt_end;
	assign accept = st_q == nor_pkg::ST_IDLE && CMD_VALID_I;
	assign order_bad = op_q == nor_pkg::OP_PROG && prog_any_q && blk_q == prog_blk_q
		&& {1'b0, pg_q} != {1'b0, prog_pg_q} + 7'h01; // [R10]
	assign refuse = op_q inside {nor_pkg::OP_PROG, nor_pkg::OP_ERASE}
		&& (!table_ready_q || bbt.rd_bad || order_bad); // [R5] [R8]

	assign bbt.rd_en = accept;
	assign bbt.rd_addr = CMD_BLOCK_I;
	assign bbt.wr_en = bbt_wr_q;
	assign bbt.wr_addr = blk_q;
	assign bbt.wr_bad = bbt_wd_q;

	assign CMD_READY_O = st_q == nor_pkg::ST_IDLE;
	assign WR_READY_O = st_q == nor_pkg::ST_LOAD && ph_q == nor_pkg::PH_IDLE;
	assign RD_DATA_O = din_q;
	assign RD_VALID_O = rd_valid_q;
	assign ECC_SYND_O = {syn_par_q, syn_idx_q};
	assign DONE_O = done_q;
	assign REFUSED_O = refused_q;
	assign FAIL_O = fail_q;
	assign STATUS_O = status_q;
	assign TABLE_READY_O = table_ready_q;

	// --------------------------------------------------------------------
	// ready/busy synchroniser
	// --------------------------------------------------------------------
	always_ff @(posedge MCLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			{rb_s3_q, rb_s2_q, rb_s1_q} <= 3'h0;
			rb_rdy_q <= 1'b0;
		end
		else
		begin
			{rb_s3_q, rb_s2_q, rb_s1_q} <= {rb_s2_q, rb_s1_q, NAND_RB_N_I};
			if (rb_s2_q == rb_s3_q)
				rb_rdy_q <= rb_s3_q;
		end
	end

	// --------------------------------------------------------------------
	// sequencer
	// --------------------------------------------------------------------
	always_ff @(posedge MCLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			st_q <= nor_pkg::ST_IDLE;
			nxt_q <= nor_pkg::ST_IDLE;
			ph_q <= nor_pkg::PH_IDLE;
			op_q <= nor_pkg::OP_READ;
			cnt_q <= '0;
			dout_q <= 8'h00;
			addr_idx_q <= 3'h0;
			remain_q <= '0;
			blk_q <= '0;
			pg_q <= '0;
			col_q <= '0;
			scan_pg_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= st_q == nor_pkg::ST_FIN && cnt_end;
			// strobe phase timing shared by every bus cycle
			if (ph_q != nor_pkg::PH_IDLE && !cnt_end)
				cnt_q <= cnt_q - nor_pkg::CNT_ONE;
			if (ph_q == nor_pkg::PH_SU && cnt_end)
			begin
				ph_q <= nor_pkg::PH_LO;
				cnt_q <= nor_pkg::WE_LO_CYC;
			end
			if (lo_end)
			begin
				ph_q <= nor_pkg::PH_HI;
				cnt_q <= wr_st ? nor_pkg::WE_HI_CYC : nor_pkg::RE_HI_CYC;
			end
			// latch lines only move at the end of a high phase or a gap, or as a setup or low phase starts from idle [R11]
			unique case (st_q)
				nor_pkg::ST_IDLE:
					if (accept)
					begin
						op_q <= nor_nor_op(CMD_OP_I);
						blk_q <= CMD_BLOCK_I;
						pg_q <= CMD_OP_I == nor_pkg::OP_SCAN ? '0 : CMD_PAGE_I;
						col_q <= CMD_OP_I == nor_pkg::OP_SCAN ? nor_pkg::SPARE_COL : CMD_COL_I;
						remain_q <= CMD_OP_I == nor_pkg::OP_SCAN ? 12'h001 : CMD_LEN_I;
						scan_pg_q <= 1'b0;
						st_q <= nor_pkg::ST_CHECK;
					end
				nor_pkg::ST_CHECK:
					if (refuse)
					begin
						st_q <= nor_pkg::ST_FIN;
						cnt_q <= nor_pkg::CNT_ONE;
					end
					else
					begin
						st_q <= nor_pkg::ST_CMD_A;
						dout_q <= first_cmd(op_q); // [R14]
						ph_q <= nor_pkg::PH_LO;
						cnt_q <= nor_pkg::WE_LO_CYC;
					end
				nor_pkg::ST_CMD_A:
					if (hi_end)
					begin
						if (op_q == nor_pkg::OP_RESET)
						begin
							st_q <= nor_pkg::ST_WB;
							ph_q <= nor_pkg::PH_IDLE;
							cnt_q <= nor_pkg::WB_CYC;
						end
						else
						begin
							st_q <= nor_pkg::ST_ADDR;
							addr_idx_q <= op_q == nor_pkg::OP_ERASE ?
								nor_pkg::ADDR_FIRST_ROW : nor_pkg::ADDR_FIRST_COL;
							dout_q <= addr_byte(op_q == nor_pkg::OP_ERASE ?
								nor_pkg::ADDR_FIRST_ROW : nor_pkg::ADDR_FIRST_COL,
								col_q, {blk_q, pg_q}); // [R13]
							ph_q <= nor_pkg::PH_LO;
							cnt_q <= nor_pkg::WE_LO_CYC;
						end
					end
				nor_pkg::ST_ADDR:
					if (hi_end)
					begin
						ph_q <= nor_pkg::PH_LO;
						cnt_q <= nor_pkg::WE_LO_CYC;
						if (addr_idx_q != nor_pkg::ADDR_LAST)
						begin
							addr_idx_q <= addr_idx_q + 3'h1;
							dout_q <= addr_byte(addr_idx_q + 3'h1, col_q, {blk_q, pg_q});
						end
						else if (op_q == nor_pkg::OP_PROG)
						begin
							st_q <= nor_pkg::ST_GAP;
							nxt_q <= nor_pkg::ST_LOAD;
							ph_q <= nor_pkg::PH_IDLE;
							cnt_q <= nor_pkg::ADL_CYC;
						end
						else
						begin
							st_q <= nor_pkg::ST_CMD_B;
							dout_q <= op_q == nor_pkg::OP_ERASE ?
								CMD_ERASE_CONFIRM : nor_pkg::CMD_READ_CONFIRM; // [R14]
						end
					end
				nor_pkg::ST_LOAD:
					// chip select released while the source has nothing [R12]
					if (ph_q == nor_pkg::PH_IDLE && WR_VALID_I)
					begin
						dout_q <= WR_DATA_I;
						ph_q <= nor_pkg::PH_SU;
						cnt_q <= nor_pkg::CS_SU_CYC;
					end
					else if (hi_end)
					begin
						if (remain_q <= 12'h001)
						begin
							st_q <= nor_pkg::ST_CMD_B;
							dout_q <= CMD_PROG_CONFIRM;
							ph_q <= nor_pkg::PH_LO;
							cnt_q <= nor_pkg::WE_LO_CYC;
						end
						else
						begin
							remain_q <= remain_q - 12'h001;
							ph_q <= nor_pkg::PH_IDLE;
						end
					end
				nor_pkg::ST_CMD_B, nor_pkg::ST_STAT_CMD:
					if (hi_end)
					begin
						st_q <= st_q == nor_pkg::ST_CMD_B ? nor_pkg::ST_WB : nor_pkg::ST_GAP;
						nxt_q <= nor_pkg::ST_STAT_RD;
						ph_q <= nor_pkg::PH_IDLE;
						cnt_q <= st_q == nor_pkg::ST_CMD_B ? nor_pkg::WB_CYC : nor_pkg::WHR_CYC;
					end
				nor_pkg::ST_WB:
					if (cnt_end)
						st_q <= nor_pkg::ST_BUSY;
					else
						cnt_q <= cnt_q - nor_pkg::CNT_ONE;
				nor_pkg::ST_BUSY:
					// array load or reset recovery ends when ready returns [R15] [R2] [R1]
					if (rb_rdy_q)
					begin
						st_q <= nor_pkg::ST_GAP;
						cnt_q <= nor_pkg::RR_CYC;
						if (op_q inside {nor_pkg::OP_READ, nor_pkg::OP_SCAN})
							nxt_q <= nor_pkg::ST_READ;
						else if (op_q == nor_pkg::OP_RESET)
							nxt_q <= nor_pkg::ST_FIN;
						else
							nxt_q <= nor_pkg::ST_STAT_CMD; // [R7]
					end
				nor_pkg::ST_GAP:
					if (!cnt_end)
						cnt_q <= cnt_q - nor_pkg::CNT_ONE;
					else
					begin
						st_q <= nxt_q;
						unique case (nxt_q)
							nor_pkg::ST_READ, nor_pkg::ST_STAT_RD:
							begin
								ph_q <= nor_pkg::PH_LO;
								cnt_q <= nor_pkg::RE_LO_CYC;
							end
							nor_pkg::ST_CMD_A, nor_pkg::ST_STAT_CMD:
							begin
								dout_q <= nxt_q == nor_pkg::ST_CMD_A ? first_cmd(op_q) : CMD_STATUS;
								ph_q <= nor_pkg::PH_LO;
								cnt_q <= nor_pkg::WE_LO_CYC;
							end
							nor_pkg::ST_FIN:
								cnt_q <= nor_pkg::RHW_CYC;
							default:
								ph_q <= nor_pkg::PH_IDLE;
						endcase
					end
				nor_pkg::ST_READ:
					if (hi_end)
					begin
						if (remain_q > 12'h001)
						begin
							remain_q <= remain_q - 12'h001;
							ph_q <= nor_pkg::PH_LO;
							cnt_q <= nor_pkg::RE_LO_CYC;
						end
						else if (op_q == nor_pkg::OP_SCAN && !scan_pg_q && din_q == nor_pkg::ERASED_BYTE)
						begin
							// marker may sit in the second page instead [R4]
							scan_pg_q <= 1'b1;
							pg_q <= pg_q + 6'h01;
							st_q <= nor_pkg::ST_GAP;
							nxt_q <= nor_pkg::ST_CMD_A;
							ph_q <= nor_pkg::PH_IDLE;
							cnt_q <= nor_pkg::RHW_CYC;
						end
						else
						begin
							st_q <= nor_pkg::ST_FIN;
							ph_q <= nor_pkg::PH_IDLE;
							cnt_q <= nor_pkg::RHW_CYC;
						end
					end
				nor_pkg::ST_STAT_RD:
					if (hi_end)
					begin
						st_q <= nor_pkg::ST_FIN;
						ph_q <= nor_pkg::PH_IDLE;
						cnt_q <= nor_pkg::RHW_CYC;
					end
				nor_pkg::ST_FIN:
					if (cnt_end)
						st_q <= nor_pkg::ST_IDLE;
					else
						cnt_q <= cnt_q - nor_pkg::CNT_ONE;
			endcase
		end
	end

	function automatic nor_pkg::nor_op_t nor_nor_op(input logic [2:0] code);
		return code > 3'h4 ? nor_pkg::OP_READ : nor_pkg::nor_op_t'(code);
	endfunction

	// --------------------------------------------------------------------
	// table upkeep, result flags and program order
	// --------------------------------------------------------------------
	always_ff @(posedge MCLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			bbt_wr_q <= 1'b0;
			bbt_wd_q <= 1'b0;
			table_ready_q <= 1'b0;
			refused_q <= 1'b0;
			fail_q <= 1'b0;
			status_q <= 8'h00;
			prog_any_q <= 1'b0;
			prog_blk_q <= '0;
			prog_pg_q <= '0;
		end
		else
		begin
			bbt_wr_q <= 1'b0;
			if (accept)
			begin
				refused_q <= 1'b0;
				fail_q <= 1'b0;
			end
			if (st_q == nor_pkg::ST_CHECK && refuse)
				refused_q <= 1'b1;
			if (st_q == nor_pkg::ST_CHECK && !refuse && op_q == nor_pkg::OP_PROG)
			begin
				prog_any_q <= 1'b1;
				prog_blk_q <= blk_q;
				prog_pg_q <= pg_q; // [R10]
			end
			if (st_q == nor_pkg::ST_CHECK && !refuse && op_q == nor_pkg::OP_ERASE
				&& blk_q == prog_blk_q)
				prog_any_q <= 1'b0;
			// any non-erased marker byte retires the block [R5] [R3] [R4]
			if (st_q == nor_pkg::ST_READ && hi_end && op_q == nor_pkg::OP_SCAN
				&& (scan_pg_q || din_q != nor_pkg::ERASED_BYTE))
			begin
				bbt_wr_q <= 1'b1;
				bbt_wd_q <= din_q != nor_pkg::ERASED_BYTE;
				if (blk_q == nor_pkg::LAST_BLK)
					table_ready_q <= 1'b1;
			end
			if (st_q == nor_pkg::ST_STAT_RD && hi_end)
			begin
				status_q <= din_q;
				fail_q <= din_q[STAT_FAIL_BIT];
				// a failed block is refused for program and erase from now on, but can still be read [R7] [R8]
				if (din_q[STAT_FAIL_BIT])
				begin
					bbt_wr_q <= 1'b1;
					bbt_wd_q <= 1'b1;
				end
			end
		end
	end

	// --------------------------------------------------------------------
	// read capture and correction syndrome
	// --------------------------------------------------------------------
	// data bus is stable around the strobe edge, so it is sampled without a synchroniser
	always_ff @(posedge MCLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			smp_q <= 1'b0;
			din_q <= 8'h00;
			rd_valid_q <= 1'b0;
			col_ptr_q <= '0;
			syn_idx_q <= '0;
			syn_par_q <= 8'h00;
		end
		else
		begin
			smp_q <= rd_st && lo_end;
			rd_valid_q <= smp_q && st_q == nor_pkg::ST_READ && op_q == nor_pkg::OP_READ;
			if (smp_q)
				din_q <= NAND_DQ_I;
			if (accept)
			begin
				col_ptr_q <= CMD_COL_I;
				syn_idx_q <= '0;
				syn_par_q <= 8'h00;
			end
			else if (smp_q && st_q == nor_pkg::ST_READ && op_q == nor_pkg::OP_READ)
			begin
				// column parity plus odd-byte position: user corrects single bits [R9]
				syn_par_q <= syn_par_q ^ NAND_DQ_I;
				if (^NAND_DQ_I)
					syn_idx_q <= syn_idx_q ^ col_ptr_q;
				col_ptr_q <= col_ptr_q + 12'h001;
			end
		end
	end

	// --------------------------------------------------------------------
	// pin drivers, registered so strobes never glitch
	// --------------------------------------------------------------------
	always_ff @(posedge MCLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			NAND_CE_N_O <= 1'b1;
			NAND_CLE_O <= 1'b0;
			NAND_ALE_O <= 1'b0;
			NAND_WE_N_O <= 1'b1;
			NAND_RE_N_O <= 1'b1;
			NAND_DQ_O <= 8'h00;
			NAND_DQ_OE_O <= 1'b0;
		end
		else
		begin
			NAND_CE_N_O <= st_q inside {nor_pkg::ST_IDLE, nor_pkg::ST_CHECK, nor_pkg::ST_FIN}
				|| (st_q == nor_pkg::ST_LOAD && ph_q == nor_pkg::PH_IDLE); // [R12]
			NAND_CLE_O <= st_q inside {nor_pkg::ST_CMD_A, nor_pkg::ST_CMD_B, nor_pkg::ST_STAT_CMD};
			NAND_ALE_O <= st_q == nor_pkg::ST_ADDR; // [R11]
			NAND_WE_N_O <= !(wr_st && ph_q == nor_pkg::PH_LO);
			NAND_RE_N_O <= !(rd_st && ph_q == nor_pkg::PH_LO);
			NAND_DQ_O <= dout_q;
			NAND_DQ_OE_O <= wr_st && ph_q != nor_pkg::PH_IDLE;
		end
	end

endmodule // nor_host

// ### design/nor_pkg.sv
// Shared constants and types for the NAND flash host controller.
// Assumes a single 125 MHz clock and one 8-bit asynchronous NAND device on the pins.
// Function
// [R1] A reset command keeps the device busy for at most 5 us when idle, or 5/10/500 us mid-op.
// [R2] The device moves a page to its data register within 40 us with the busy line low.
// [R3] Every shipped location except factory bad-block markers reads as all-ones.
// [R4] A factory bad block has a non-all-ones byte at column 2048 of its first or second page.
// [R5] The host scans the markers into a bad-block table before erasing and masks those blocks.
// [R6] Block zero is valid for up to 1K program/erase cycles with 1-bit correction per 528 bytes.
// [R7] The host reads status after every program or erase and retires a block that failed.
// [R8] A failed block is replaced by copying its pages and is never programmed or erased again; code marks it bad, no copying.
// [R9] The host applies error correction to read data and keeps blocks with single-bit errors; code only outputs ECC_SYND_O.
// [R10] Pages in a block are programmed in ascending consecutive order from any start page; code checks only the last programmed block.
// [R11] While write strobe is low, command-latch, address-latch and chip select change at most once.
// [R12] Chip select may go inactive during data loading or readout without losing position.
// [R13] Five address cycles carry column bits 0-7, 8-11 and row bits 12-19, 20-27 and 28.
// [R14] A page read is read setup, five address cycles, then read confirm.
// [R15] The host waits for the ready/busy line before reading data out.
package nor_pkg;

	// --------------------------------------------------------------------
	// timing
	// --------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;

	function automatic int cyc_ceil(input int ns);
		return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction

	localparam int T_WP_NS = 12;
	localparam int T_WH_NS = 10;
	localparam int T_CS_NS = 20;
	localparam int T_ADL_NS = 100;
	localparam int T_WB_NS = 100;
	localparam int T_RR_NS = 20;
	localparam int T_REA_NS = 20;
	localparam int T_REH_NS = 15;
	localparam int T_RHW_NS = 100;
	localparam int T_WHR_NS = 60;
	localparam int RB_SYNC_CYC = 3;

	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	localparam logic [CNT_W-1:0] WE_LO_CYC = CNT_W'(cyc_ceil(T_WP_NS));
	localparam logic [CNT_W-1:0] WE_HI_CYC = CNT_W'(cyc_ceil(T_WH_NS));
	localparam logic [CNT_W-1:0] CS_SU_CYC = CNT_W'(cyc_ceil(T_CS_NS));
	localparam logic [CNT_W-1:0] ADL_CYC = CNT_W'(cyc_ceil(T_ADL_NS));
	// busy may appear only after the synchroniser delay
	localparam logic [CNT_W-1:0] WB_CYC = CNT_W'(cyc_ceil(T_WB_NS) + RB_SYNC_CYC);
	localparam logic [CNT_W-1:0] RR_CYC = CNT_W'(cyc_ceil(T_RR_NS));
	// one extra cycle since the sample edge is the strobe's rising edge
	localparam logic [CNT_W-1:0] RE_LO_CYC = CNT_W'(cyc_ceil(T_REA_NS) + 1);
	localparam logic [CNT_W-1:0] RE_HI_CYC = CNT_W'(cyc_ceil(T_REH_NS));
	localparam logic [CNT_W-1:0] RHW_CYC = CNT_W'(cyc_ceil(T_RHW_NS));
	localparam logic [CNT_W-1:0] WHR_CYC = CNT_W'(cyc_ceil(T_WHR_NS));

	// --------------------------------------------------------------------
	// geometry and codes
	// --------------------------------------------------------------------
	localparam int COL_W = 12;
	localparam int PAGE_W = 6;
	localparam int BLK_W = 11;
	localparam int ROW_W = PAGE_W + BLK_W;
	localparam int LEN_W = 12;
	localparam int NUM_BLOCKS = 2048;
	localparam logic [COL_W-1:0] SPARE_COL = 12'h800;
	localparam logic [BLK_W-1:0] LAST_BLK = 11'h7FF;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] CMD_READ_SETUP = 8'h00;
	localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [2:0] ADDR_FIRST_COL = 3'h0;
	localparam logic [2:0] ADDR_FIRST_ROW = 3'h2;
	localparam logic [2:0] ADDR_LAST = 3'h4;

	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_PROG = 3'h1,
		OP_ERASE = 3'h2,
		OP_RESET = 3'h3,
		OP_SCAN = 3'h4
	} nor_op_t;

	typedef enum {
		ST_IDLE, ST_CHECK, ST_CMD_A, ST_ADDR, ST_LOAD, ST_CMD_B, ST_WB,
		ST_BUSY, ST_GAP, ST_READ, ST_STAT_CMD, ST_STAT_RD, ST_FIN
	} nor_state_t;

	typedef enum {PH_IDLE, PH_SU, PH_LO, PH_HI} nor_phase_t;

endpackage

// ### design/nor_bbt_if.sv
// Port bundle between the sequencer and its bad-block table.
// Assumes both ends run on the controller clock.
interface nor_bbt_if;
	logic rd_en;
	logic [nor_pkg::BLK_W-1:0] rd_addr;
	logic rd_bad;
	logic wr_en;
	logic [nor_pkg::BLK_W-1:0] wr_addr;
	logic wr_bad;

	modport ctrl (output rd_en, output rd_addr, input rd_bad,
		output wr_en, output wr_addr, output wr_bad);
	modport mem (input rd_en, input rd_addr, output rd_bad,
		input wr_en, input wr_addr, input wr_bad);
endinterface

// ### design/nor_bbt_mem.sv
// One bad flag per block; registered read data.
// Assumes every entry is written by a scan before it is trusted.
module nor_bbt_mem (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// table access
	nor_bbt_if.mem port
);
	logic mem_q [nor_pkg::NUM_BLOCKS];

	always_ff @(posedge clk_i)
	begin
		if (port.wr_en)
			mem_q[port.wr_addr] <= port.wr_bad;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			port.rd_bad <= 1'b0;
		else if (port.rd_en)
			port.rd_bad <= mem_q[port.rd_addr];
	end
endmodule // nor_bbt_mem

// ### sim/nor_host_monitor.sv
// Checker on the host controller's flash pins and command handshake.
// Assumes a bind onto every nor_host instance.
module nor_host_monitor (
	// watched ports
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	input wire logic CMD_VALID_I,
	input wire logic CMD_READY_O,
	input wire logic DONE_O,
	input wire logic REFUSED_O,
	input wire logic TABLE_READY_O,
	input wire logic NAND_CE_N_O,
	input wire logic NAND_CLE_O,
	input wire logic NAND_ALE_O,
	input wire logic NAND_WE_N_O,
	input wire logic NAND_RE_N_O,
	input wire logic [7:0] NAND_DQ_O,
	input wire logic NAND_DQ_OE_O,
	input wire logic NAND_RB_N_I
);
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	latch_hold_a: assert property (!NAND_WE_N_O && !$past(NAND_WE_N_O)
		|-> $stable({NAND_CLE_O, NAND_ALE_O, NAND_CE_N_O, NAND_DQ_O})) else $error("latch moved");
	write_select_a: assert property ($fell(NAND_WE_N_O) |-> !NAND_CE_N_O && NAND_DQ_OE_O)
		else $error("write unselected");
	strobe_excl_a: assert property (!(!NAND_WE_N_O && !NAND_RE_N_O)
		&& !(NAND_CLE_O && NAND_ALE_O)) else $error("strobes overlap");
	read_ready_a: assert property ($fell(NAND_RE_N_O) |-> $past(NAND_RB_N_I, 3))
		else $error("read while busy");
	bus_turn_a: assert property (!NAND_RE_N_O |-> !NAND_DQ_OE_O)
		else $error("bus contention");
	refuse_quiet_a: assert property (DONE_O && REFUSED_O |-> NAND_CE_N_O
		&& $past(NAND_CE_N_O) && $past(NAND_CE_N_O, 2)) else $error("refused op moved pins");
	table_sticky_a: assert property (TABLE_READY_O |=> TABLE_READY_O)
		else $error("table ready lost");
	take_drop_a: assert property (CMD_VALID_I && CMD_READY_O |=> !CMD_READY_O [*2])
		else $error("ready after take");
endmodule // nor_host_monitor

bind nor_host nor_host_monitor u_nor_host_monitor (.*);

// ### sim/nor_flash_model.sv
// Behavioural 8-bit flash device on the host pins.
// Assumes one device; busy times are short but inside the maxima.
module nor_flash_model #(
	parameter int BAD = 3,
	parameter int FL = 4
) (
	// host pins
	input wire logic ce_n_i,
	input wire logic cle_i,
	input wire logic ale_i,
	input wire logic we_n_i,
	input wire logic re_n_i,
	input wire logic [7:0] dq_i,
	// device outputs
	output logic [7:0] dq_o,
	output logic rb_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [int];
	logic [7:0] pg [0:2111];
	logic [7:0] st;
	logic [11:0] col;
	logic [16:0] row;
	int na;
	int t;
	bit sm;
	function automatic int key(input int c);
		return row * 4096 + c;
	endfunction
	initial
	begin
		rb_n_o = 1'b1;
		dq_o = 8'h00;
		mem[(BAD * 64 + 1) * 4096 + 2048] = 8'h00;
	end
	always @(posedge we_n_i)
	begin
		if (!ce_n_i && cle_i)
		begin
			sm = dq_i == 8'h70;
			na = dq_i == 8'h60 ? 2 : 0;
			for (int k = 0; k < 2112; k++)
			begin
				if (dq_i == 8'h30 || dq_i == 8'h80)
					pg[k] = dq_i == 8'h80 || !mem.exists(key(k)) ? 8'hFF : mem[key(k)];
				// the failing block FL keeps none of its programmed bytes
				if (dq_i == 8'h10 && row[16:6] != FL && pg[k] != 8'hFF)
					mem[key(k)] = mem.exists(key(k)) ? mem[key(k)] & pg[k] : pg[k];
			end
			for (int k = 0; k < 262144 && dq_i == 8'hD0; k++)
				if (mem.exists(row[16:6] * 262144 + k))
					mem.delete(row[16:6] * 262144 + k);
			st = row[16:6] == FL ? 8'hC1 : 8'hC0;
			t = dq_i == 8'h30 ? 400 : dq_i == 8'h10 ? 800 : dq_i == 8'hD0 ? 1000 : 0;
			t = dq_i == 8'hFF ? 1000 : t;
			if (t > 0)
			begin
				rb_n_o <= #20 1'b0;
				rb_n_o <= #(20 + t) 1'b1;
			end
		end
		else if (!ce_n_i && ale_i)
		begin
			case (na)
			0: col[7:0] = dq_i;
			1: col[11:8] = dq_i[3:0];
			2: row[7:0] = dq_i;
			3: row[15:8] = dq_i;
			default: row[16] = dq_i[0];
			endcase
			na++;
		end
		else if (!ce_n_i)
		begin
			pg[col] = dq_i;
			col++;
		end
	end
	always @(negedge re_n_i)
		if (!ce_n_i)
			dq_o <= #15 sm ? st : pg[col];
	always @(posedge re_n_i)
	begin
		col = col + (sm ? 12'h000 : 12'h001);
		// released bus shows the inverse of the last byte
		dq_o <= #15 ~dq_o;
	end
endmodule // nor_flash_model

// ### sim/testbench.sv
// Self-checking bench: host controller against the flash model.
// Assumes the model's bad and failing blocks given below.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BAD = 3;
	localparam int FL = 4;
	logic MCLK_I = '0, RST_N_I = '0, CMD_VALID_I = '0, WR_VALID_I = '0, tk;
	logic [2:0] CMD_OP_I = '0;
	logic [10:0] CMD_BLOCK_I = '0;
	logic [5:0] CMD_PAGE_I = '0;
	logic [11:0] CMD_COL_I = '0, CMD_LEN_I = '0;
	logic [7:0] WR_DATA_I = '0, dev_dq, NAND_DQ_I, RD_DATA_O, STATUS_O, NAND_DQ_O;
	logic [19:0] ECC_SYND_O;
	logic CMD_READY_O, WR_READY_O, RD_VALID_O, DONE_O, REFUSED_O, FAIL_O, TABLE_READY_O;
	logic NAND_CE_N_O, NAND_CLE_O, NAND_ALE_O, NAND_WE_N_O, NAND_RE_N_O, NAND_DQ_OE_O, NAND_RB_N_I;
	logic [7:0] m [int];
	logic [7:0] wq [$], rq [$];
	int n_fail = 0, comparisons = 0;
	always #4 MCLK_I = ~MCLK_I;
	assign NAND_DQ_I = NAND_DQ_OE_O ? NAND_DQ_O : dev_dq;
	nor_host u_nor_host (.*);
	nor_flash_model #(.BAD(BAD), .FL(FL)) u_nor_flash_model (.ce_n_i(NAND_CE_N_O),
		.cle_i(NAND_CLE_O), .ale_i(NAND_ALE_O), .we_n_i(NAND_WE_N_O), .re_n_i(NAND_RE_N_O),
		.dq_i(NAND_DQ_O), .dq_o(dev_dq), .rb_n_o(NAND_RB_N_I));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic run(input int op, input int b, input int p, input int c, input int n,
		input bit rf);
		int k;
		logic [7:0] v;
		logic [19:0] sy;
		sy = '0;
		for (int i = 0; i < n; i++)
		begin
			k = (b * 64 + p) * 4096 + c + i;
			v = 8'($urandom);
			if (op == 1 && !rf)
				wq.push_back(v);
			if (op == 1 && !rf && b != FL)
				m[k] = m.exists(k) ? m[k] & v : v;
			v = m.exists(k) ? m[k] : 8'hFF;
			if (op == 0 || op > 4)
				rq.push_back(v);
			if (op == 0 || op > 4)
				sy ^= {v, ^v ? 12'(c + i) : 12'h000};
		end
		for (k = b * 262144; op == 2 && k < (b + 1) * 262144; k++)
			if (m.exists(k))
				m.delete(k);
		CMD_OP_I = 3'(op);
		CMD_BLOCK_I = 11'(b);
		CMD_PAGE_I = 6'(p);
		CMD_COL_I = 12'(c);
		CMD_LEN_I = 12'(n);
		CMD_VALID_I = 1'b1;
		// ready is read mid-cycle, away from the edge that moves it
		@(negedge MCLK_I);
		while (CMD_READY_O !== 1'b1)
			@(negedge MCLK_I);
		@(posedge MCLK_I) #1;
		CMD_VALID_I = 1'b0;
		for (k = 0; k < 30000 && DONE_O !== 1'b1; k++)
			@(posedge MCLK_I) #1;
		check(DONE_O, 1'b1);
		check(REFUSED_O, rf);
		check(rq.size(), 0);
		if (op == 0 || op > 4)
			check(ECC_SYND_O, sy);
		if (op > 0 && op < 3 && !rf)
			check({FAIL_O, STATUS_O}, b == FL ? 9'h1C1 : 9'h0C0);
		$display("test op %0d block %0d page %0d done", op, b, p);
	endtask
	// outputs read mid-cycle; inputs move just after the edge that follows
	always @(negedge MCLK_I)
	begin
		if (RD_VALID_O === 1'b1)
			check(RD_DATA_O, rq.size() > 0 ? rq.pop_front() : 32'h100);
		tk = WR_VALID_I && WR_READY_O;
		@(posedge MCLK_I) #1;
		if (tk)
			void'(wq.pop_front());
		if (tk || !WR_VALID_I)
			WR_VALID_I = wq.size() > 0 && $urandom % 2;
		WR_DATA_I = wq.size() > 0 ? wq[0] : 8'h00;
	end
	initial
	begin
		void'($urandom(32'h53713A1A));
		m[(BAD * 64 + 1) * 4096 + 2048] = 8'h00;
		repeat (20) @(posedge MCLK_I);
		check({NAND_CE_N_O, NAND_WE_N_O, NAND_RE_N_O, NAND_DQ_OE_O, TABLE_READY_O}, 5'h1C);
		#1 RST_N_I = 1'b1;
		run(1, 1, 2, 0, 4, 1);
		for (int b = 0; b < 5; b++)
			run(4, b, 0, 0, 1, 0);
		run(4, 2047, 0, 0, 1, 0);
		check(TABLE_READY_O, 1);
		run(1, BAD, 0, 0, 2, 1);
		run(1, 0, 0, $urandom % 2048, 3, 0);
		run(1, 1, 2, 100, 4, 0);
		run(1, 1, 5, 0, 2, 1);
		run(1, 1, 3, 2045, 8, 0);
		run(0, 1, 2, 98, 8, 0);
		run(0, 1, 3, 2045, 8, 0);
		run(0, 0, 0, 0, 3, 0);
		run(1, FL, 0, 0, 2, 0);
		run(1, FL, 1, 0, 2, 1);
		run(2, 1, 0, 0, 0, 0);
		run(5, 1, 2, 100, 2, 0);
		run(3, 0, 0, 0, 0, 0);
		run(1, 1, 0, 0, 1, 0);
		stop_test();
	end
	initial
	begin
		#400us;
		n_fail++;
		stop_test();
	end
endmodule // testbench
